// file: hw/sample_output_interface_mux.sv
module sample_output_interface_mux
    import som_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic rd_sclk,
    input wire logic interface_select,
    input wire logic byte_mode_select,
    input wire logic high_byte_first,
    input wire logic reference_select,
    input wire logic [15:0] result_a,
    input wire logic [15:0] result_b,
    output logic [15:0] parallel_result_bus_o,
    output logic [15:0] parallel_result_bus_oe,
    output logic reference_pin_oe
);
    som_pins_if pins ();
    som_state_t st_q;
    som_state_t st_d;
    som_mode_t mode;
    logic cs_fall;
    logic cs_rise;
    logic rd_rise;
    logic sel_high;

    som_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .raw({reference_select, high_byte_first, byte_mode_select,
              interface_select, rd_sclk, cs_b}),
        .pins(pins.sync)
    );

    function automatic som_mode_t decode_mode(input logic isel, input logic bsel);
        if (!isel) begin
            decode_mode = SOM_MODE_PARALLEL;
        end else if (bsel) begin
            decode_mode = SOM_MODE_BYTE;
        end else begin
            decode_mode = SOM_MODE_SERIAL;
        end
    endfunction

    assign mode = decode_mode(pins.interface_select, pins.byte_mode_select);
    assign cs_fall = st_q.cs_prev && !pins.cs_b;
    assign cs_rise = !st_q.cs_prev && pins.cs_b;
    assign rd_rise = !st_q.rd_prev && pins.rd_sclk;

    always_comb begin
        st_d = st_q;
        st_d.cs_prev = pins.cs_b;
        st_d.rd_prev = pins.rd_sclk;
        st_d.ref_en = pins.reference_select;
        // The word is frozen for the whole access so a new result cannot tear it.
        if (cs_fall) begin
            st_d.hold = result_a;
            st_d.sh_a = result_a;
            st_d.sh_b = result_b;
            st_d.phase = 1'b0;
        end else if (!pins.cs_b && rd_rise) begin
            st_d.sh_a = {st_q.sh_a[14:0], 1'b0};
            st_d.sh_b = {st_q.sh_b[14:0], 1'b0};
            if (mode == SOM_MODE_BYTE) begin
                st_d.phase = !st_q.phase;
            end
        end else if (cs_rise) begin
            st_d.phase = 1'b0;
        end
        sel_high = pins.high_byte_first ^ st_d.phase;
        st_d.bus_o = SOM_WORD_RST;
        st_d.bus_oe = SOM_OE_NONE;
        if (!pins.cs_b) begin
            case (mode)
                SOM_MODE_PARALLEL: begin
                    st_d.bus_o = st_d.hold;
                    if (!pins.rd_sclk) begin
                        st_d.bus_oe = SOM_OE_ALL;
                    end
                end
                SOM_MODE_BYTE: begin
                    st_d.bus_o[7:0] = sel_high ? st_d.hold[15:8] : st_d.hold[7:0];
                    if (!pins.rd_sclk) begin
                        st_d.bus_oe = SOM_OE_BYTE;
                    end
                end
                default: begin
                    // Pins 9..13 are host-held inputs here, so only the two outputs drive.
                    st_d.bus_o[SOM_SER_A_BIT] = st_d.sh_a[15];
                    st_d.bus_o[SOM_SER_B_BIT] = st_d.sh_b[15];
                    st_d.bus_oe = SOM_OE_SERIAL;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{cs_prev: 1'b1, rd_prev: 1'b1, phase: 1'b0, hold: SOM_WORD_RST,
                      sh_a: SOM_WORD_RST, sh_b: SOM_WORD_RST, bus_o: SOM_WORD_RST,
                      bus_oe: SOM_OE_NONE, ref_en: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign parallel_result_bus_o = st_q.bus_o;
    assign parallel_result_bus_oe = st_q.bus_oe;
    assign reference_pin_oe = st_q.ref_en;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_par_oe;
        (mode == SOM_MODE_PARALLEL && !pins.cs_b && !pins.rd_sclk)
            |=> (parallel_result_bus_oe == SOM_OE_ALL);
    endproperty
    a_par_oe: assert property (p_par_oe) else $error("Bus off on read.");

    property p_par_latch;
        (mode == SOM_MODE_PARALLEL && cs_fall)
            |=> (parallel_result_bus_o == $past(result_a));
    endproperty
    a_par_latch: assert property (p_par_latch) else $error("Word not latched.");

    property p_par_data;
        (mode == SOM_MODE_PARALLEL && !pins.cs_b && !cs_fall)
            |=> (parallel_result_bus_o == st_q.hold);
    endproperty
    a_par_data: assert property (p_par_data) else $error("Parallel word mismatch.");

    property p_par_rd_high;
        (mode == SOM_MODE_PARALLEL && pins.rd_sclk) |=> (parallel_result_bus_oe == SOM_OE_NONE);
    endproperty
    a_par_rd_high: assert property (p_par_rd_high) else $error("Bus on, strobe high.");

    property p_cs_high;
        pins.cs_b |=> (parallel_result_bus_oe == SOM_OE_NONE);
    endproperty
    a_cs_high: assert property (p_cs_high) else $error("Bus on, select high.");

    property p_ser_msb;
        (mode == SOM_MODE_SERIAL && cs_fall)
            |=> (parallel_result_bus_oe == SOM_OE_SERIAL)
                && (parallel_result_bus_o[SOM_SER_A_BIT] == $past(result_a[15]))
                && (parallel_result_bus_o[SOM_SER_B_BIT] == $past(result_b[15]));
    endproperty
    a_ser_msb: assert property (p_ser_msb) else $error("Serial MSB not presented.");

    property p_ser_shift;
        (mode == SOM_MODE_SERIAL && !pins.cs_b && !cs_fall && rd_rise)
            |=> (parallel_result_bus_o[SOM_SER_A_BIT] == $past(st_q.sh_a[14]));
    endproperty
    a_ser_shift: assert property (p_ser_shift) else $error("Serial bit not shifted.");

    property p_ser_oe;
        (mode == SOM_MODE_SERIAL && !pins.cs_b) |=> (parallel_result_bus_oe == SOM_OE_SERIAL);
    endproperty
    a_ser_oe: assert property (p_ser_oe) else $error("Serial outputs off.");

    property p_ser_shift_b;
        (mode == SOM_MODE_SERIAL && !pins.cs_b && !cs_fall && rd_rise)
            |=> (parallel_result_bus_o[SOM_SER_B_BIT] == $past(st_q.sh_b[14]));
    endproperty
    a_ser_shift_b: assert property (p_ser_shift_b) else $error("B not shifted.");

    property p_byte_oe;
        (mode == SOM_MODE_BYTE && !pins.cs_b && !pins.rd_sclk)
            |=> (parallel_result_bus_oe == SOM_OE_BYTE);
    endproperty
    a_byte_oe: assert property (p_byte_oe) else $error("Byte mode lanes wrong.");

    property p_byte_rd_high;
        (mode == SOM_MODE_BYTE && pins.rd_sclk) |=> (parallel_result_bus_oe == SOM_OE_NONE);
    endproperty
    a_byte_rd_high: assert property (p_byte_rd_high) else $error("Byte lanes on.");

    property p_byte_latch;
        (mode == SOM_MODE_BYTE && cs_fall)
            |=> (parallel_result_bus_o[7:0] == ($past(pins.high_byte_first)
                 ? $past(result_a[15:8]) : $past(result_a[7:0])));
    endproperty
    a_byte_latch: assert property (p_byte_latch) else $error("First byte not latched.");

    property p_byte_first;
        (mode == SOM_MODE_BYTE && !pins.cs_b && !cs_fall && !rd_rise && !st_q.phase)
            |=> (parallel_result_bus_o[7:0]
                 == ($past(pins.high_byte_first) ? st_q.hold[15:8] : st_q.hold[7:0]));
    endproperty
    a_byte_first: assert property (p_byte_first) else $error("Wrong first byte.");

    property p_byte_second;
        (mode == SOM_MODE_BYTE && !pins.cs_b && !cs_fall && !rd_rise && st_q.phase)
            |=> (parallel_result_bus_o[7:0]
                 == ($past(pins.high_byte_first) ? st_q.hold[7:0] : st_q.hold[15:8]));
    endproperty
    a_byte_second: assert property (p_byte_second) else $error("Wrong second byte.");

    property p_byte_phase;
        (mode == SOM_MODE_BYTE && !pins.cs_b && !cs_fall && rd_rise)
            |=> (st_q.phase != $past(st_q.phase));
    endproperty
    a_byte_phase: assert property (p_byte_phase) else $error("Phase not toggled.");

    property p_byte_phase_clr;
        (mode == SOM_MODE_BYTE && cs_rise) |=> !st_q.phase;
    endproperty
    a_byte_phase_clr: assert property (p_byte_phase_clr) else $error("Phase kept.");

    property p_ref;
        ##1 1'b1 |-> (reference_pin_oe == $past(pins.reference_select));
    endproperty
    a_ref: assert property (p_ref) else $error("Reference enable mismatch.");
endmodule

// file: hw/som_pkg.sv
package som_pkg;
    localparam int SOM_WORD_W = 16;
    localparam int SOM_BYTE_W = 8;
    localparam int SOM_SYNC_W = 6;
    localparam int SOM_SER_A_BIT = 7;
    localparam int SOM_SER_B_BIT = 8;
    localparam logic [15:0] SOM_OE_NONE = 16'h0000;
    localparam logic [15:0] SOM_OE_ALL = 16'hFFFF;
    localparam logic [15:0] SOM_OE_BYTE = 16'h00FF;
    localparam logic [15:0] SOM_OE_SERIAL = 16'h0180;
    localparam logic [15:0] SOM_WORD_RST = 16'h0000;
    localparam logic [1:0] SOM_SYNC_RST = 2'h3;

    typedef enum logic [1:0] {
        SOM_MODE_PARALLEL = 2'b00,
        SOM_MODE_SERIAL = 2'b01,
        SOM_MODE_BYTE = 2'b10
    } som_mode_t;

    typedef struct packed {
        logic cs_prev;
        logic rd_prev;
        logic phase;
        logic [15:0] hold;
        logic [15:0] sh_a;
        logic [15:0] sh_b;
        logic [15:0] bus_o;
        logic [15:0] bus_oe;
        logic ref_en;
    } som_state_t;
endpackage

// file: hw/som_pins_if.sv
interface som_pins_if;
    logic cs_b;
    logic rd_sclk;
    logic interface_select;
    logic byte_mode_select;
    logic high_byte_first;
    logic reference_select;

    modport sync (
        output cs_b,
        output rd_sclk,
        output interface_select,
        output byte_mode_select,
        output high_byte_first,
        output reference_select
    );
    modport core (
        input cs_b,
        input rd_sclk,
        input interface_select,
        input byte_mode_select,
        input high_byte_first,
        input reference_select
    );
endinterface

// file: hw/som_pin_sync.sv
module som_pin_sync
    import som_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [5:0] raw,
    som_pins_if.sync pins
);
    logic [5:0] meta_q;
    logic [5:0] sync_q;

    // Chip select and read strobe idle high, so they reset high.
    genvar i;
    generate
        for (i = 0; i < SOM_SYNC_W; i++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q[i] <= (i < 2) ? SOM_SYNC_RST[0] : 1'b0;
                    sync_q[i] <= (i < 2) ? SOM_SYNC_RST[1] : 1'b0;
                end else begin
                    meta_q[i] <= raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign pins.cs_b = sync_q[0];
    assign pins.rd_sclk = sync_q[1];
    assign pins.interface_select = sync_q[2];
    assign pins.byte_mode_select = sync_q[3];
    assign pins.high_byte_first = sync_q[4];
    assign pins.reference_select = sync_q[5];
endmodule

// file: verification/som_host_model.sv
module som_host_model
    import som_pkg::*;
(
    input wire logic ref_clk,
    input wire logic interface_select,
    input wire logic [15:0] bus_o,
    input wire logic [15:0] bus_oe,
    output logic cs_b,
    output logic rd_sclk,
    output logic [15:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_q = SOM_WORD_RST;
    logic [15:0] tie;
    // Released lines toggle every cycle so that a stale value cannot pass for a driven one; tied lines 9..13 are held low instead.
    assign tie = interface_select ? 16'h3E00 : SOM_OE_NONE;
    assign seen = (bus_oe & bus_o) | (~bus_oe & ~tie & ~last_q);
    always @(posedge ref_clk) last_q <= seen;
    initial begin
        cs_b = 1'b1;
        rd_sclk = 1'b1;
    end
    // Each pin level stands ten cycles, half of the 80 ns serial clock period.
    task automatic drive(input logic c, input logic r);
        @(negedge ref_clk);
        cs_b = c;
        rd_sclk = r;
        repeat (9) @(negedge ref_clk);
    endtask
endmodule

// file: verification/sample_output_interface_mux_bench.sv
module sample_output_interface_mux_bench
    import som_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic isel = 1'b0;
    logic bsel = 1'b0;
    logic hbf = 1'b0;
    logic rsel = 1'b0;
    logic [15:0] res_a = 16'hA5C3;
    logic [15:0] res_b = 16'h3C96;
    logic cs_b;
    logic rd_sclk;
    logic ref_oe;
    logic [15:0] bus_o;
    logic [15:0] bus_oe;
    logic [15:0] seen;
    int n_errors = 0;
    int checks_done = 0;
    always #2 ref_clk = ~ref_clk;
    sample_output_interface_mux i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b),
        .rd_sclk(rd_sclk), .interface_select(isel), .byte_mode_select(bsel),
        .high_byte_first(hbf), .reference_select(rsel), .result_a(res_a), .result_b(res_b),
        .parallel_result_bus_o(bus_o), .parallel_result_bus_oe(bus_oe),
        .reference_pin_oe(ref_oe));
    som_host_model i_host (.ref_clk(ref_clk), .interface_select(isel), .bus_o(bus_o),
        .bus_oe(bus_oe), .cs_b(cs_b), .rd_sclk(rd_sclk), .seen(seen));
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic set_mode(input logic i, input logic b, input logic h, input logic r);
        @(negedge ref_clk);
        isel = i;
        bsel = b;
        hbf = h;
        rsel = r;
        repeat (10) @(negedge ref_clk);
    endtask
    task automatic test_reset();
        check("oe after reset", bus_oe, SOM_OE_NONE);
        check("ref after reset", {15'h0000, ref_oe}, 16'h0000);
        set_mode(1'b0, 1'b0, 1'b0, 1'b1);
        check("ref on", {15'h0000, ref_oe}, 16'h0001);
        set_mode(1'b0, 1'b0, 1'b0, 1'b0);
        check("ref off", {15'h0000, ref_oe}, 16'h0000);
    endtask
    task automatic test_parallel();
        i_host.drive(1'b0, 1'b1);
        check("par oe cs only", bus_oe, SOM_OE_NONE);
        // The word was taken at chip select fall, so a new result must not show.
        res_a = 16'h5A3C;
        i_host.drive(1'b0, 1'b0);
        check("par oe read", bus_oe, SOM_OE_ALL);
        check("par word", seen, 16'hA5C3);
        i_host.drive(1'b0, 1'b1);
        check("par oe after read", bus_oe, SOM_OE_NONE);
        i_host.drive(1'b1, 1'b0);
        check("par oe rd only", bus_oe, SOM_OE_NONE);
        i_host.drive(1'b1, 1'b1);
    endtask
    task automatic test_byte(input logic h);
        set_mode(1'b1, 1'b1, h, 1'b0);
        i_host.drive(1'b0, 1'b0);
        check("byte oe", bus_oe, SOM_OE_BYTE);
        check("first byte", {8'h00, seen[7:0]}, {8'h00, h ? res_a[15:8] : res_a[7:0]});
        i_host.drive(1'b0, 1'b1);
        check("byte oe gap", bus_oe, SOM_OE_NONE);
        i_host.drive(1'b0, 1'b0);
        check("second byte", {8'h00, seen[7:0]}, {8'h00, h ? res_a[7:0] : res_a[15:8]});
        i_host.drive(1'b1, 1'b1);
        check("byte oe end", bus_oe, SOM_OE_NONE);
    endtask
    task automatic test_serial();
        set_mode(1'b1, 1'b0, 1'b0, 1'b0);
        i_host.drive(1'b0, 1'b1);
        for (int i = 15; i >= 0; i--) begin
            check("ser oe", bus_oe, SOM_OE_SERIAL);
            check("ser bits", {14'h0000, seen[8:7]}, {14'h0000, res_b[i], res_a[i]});
            i_host.drive(1'b0, 1'b0);
            check("ser oe clock low", bus_oe, SOM_OE_SERIAL);
            i_host.drive(1'b0, 1'b1);
        end
        i_host.drive(1'b1, 1'b1);
        check("ser oe end", bus_oe, SOM_OE_NONE);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        test_reset();
        test_parallel();
        test_byte(1'b0);
        test_byte(1'b1);
        test_serial();
        test_done();
    end
    initial begin
        #100us;
        n_errors++;
        test_done();
    end
endmodule
